// *** dog_defs.vh ***
// Purpose: Constants for the watchdog reset timer
// Assumes: 250 MHz system clock, 32-bit AXI4-Lite register words
// Notes:   Offsets are byte addresses
`ifndef DOG_DEFS_VH
`define DOG_DEFS_VH

// ****************************************
// Register offsets
// ****************************************
`define DOG_CTRL_OFS        4'h0
`define DOG_STAT_OFS        4'h4
`define DOG_KICK_OFS        4'h8

// ****************************************
// Control fields
// ****************************************
`define DOG_CTRL_EN_BIT     0
`define DOG_CTRL_WAKE_BIT   1
`define DOG_CTRL_RSTEN_BIT  2
`define DOG_CTRL_SEL_LSB    4
`define DOG_CTRL_SEL_MSB    7
`define DOG_CTRL_DLY_LSB    8
`define DOG_CTRL_DLY_MSB    9

// ****************************************
// Status fields
// ****************************************
`define DOG_STAT_TOF_BIT    0
`define DOG_STAT_RSTF_BIT   1
`define DOG_STAT_WKF_BIT    2
`define DOG_STAT_CNT_LSB    8

// ****************************************
// Timing and sizes
// ****************************************
`define DOG_CNT_W           18
`define DOG_SEL_MIN         4
`define DOG_SEL_MAX         18
`define DOG_HOLD_TICKS      6'h3f
`define DOG_DLY_0           11'h003
`define DOG_DLY_1           11'h012
`define DOG_DLY_2           11'h082
`define DOG_DLY_3           11'h402
`define DOG_KICK_KEY        32'h00005aa5

`endif

// *** watchdog_reset_timer.v ***
// Purpose: Watchdog timer that resets the system when software stops servicing it
// Assumes: dog_tick_clock_i is a slow free clock, sampled through three flops
// Notes:   AXI4-Lite slave, one outstanding write and one outstanding read
//
// Behaviour
// [R01] Force whole-system reset when the time-out elapses unserviced.
// [R02] Time-out measured by an 18-bit free running up counter on tick clock.
// [R03] Time-out is two to the 4th through 18th tick cycles, software chosen.
// [R04] Once fired, hold system reset exactly 63 tick periods.
// [R05] Programmable delay of 3, 18, 130 or 1026 ticks before reset.
// [R06] Watchdog forced on after any reset when boot enable bit is zero.
// [R07] Time-out may wake from Idle or Power-down only with 10 kHz source selected.
// [R08] Software clears the counter before the time-out elapses.
//
// Local design decisions: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "dog_defs.vh"

module watchdog_reset_timer
(
	input  wire        sys_clk_i,
	input  wire        rst_i,
	input  wire        dog_tick_clock_i,
	input  wire        boot_force_dog_on_bit_i,
	input  wire        src_is_10khz_i,
	input  wire        low_power_i,
	input  wire [31:0] s_axi_awaddr_i,
	input  wire        s_axi_awvalid_i,
	output wire        s_axi_awready_o,
	input  wire [31:0] s_axi_wdata_i,
	input  wire [3:0]  s_axi_wstrb_i,
	input  wire        s_axi_wvalid_i,
	output wire        s_axi_wready_o,
	output wire [1:0]  s_axi_bresp_o,
	output wire        s_axi_bvalid_o,
	input  wire        s_axi_bready_i,
	input  wire [31:0] s_axi_araddr_i,
	input  wire        s_axi_arvalid_i,
	output wire        s_axi_arready_o,
	output wire [31:0] s_axi_rdata_o,
	output wire [1:0]  s_axi_rresp_o,
	output wire        s_axi_rvalid_o,
	input  wire        s_axi_rready_i,
	output wire        sys_reset_o,
	output wire        wake_o
);

	localparam ST_RUN   = 2'd0;
	localparam ST_DELAY = 2'd1;
	localparam ST_HOLD  = 2'd2;

	// ****************************************
	// Tick clock sampling
	// ****************************************
	reg  [2:0]                tick_sync_ff;
	reg                       tick_prev_ff;
	wire                      tick_agree = (tick_sync_ff[2] == tick_sync_ff[1]);
	wire                      tick_rise  = tick_agree & tick_sync_ff[2] & ~tick_prev_ff;

	always @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			tick_sync_ff <= 3'h0;
			tick_prev_ff <= 1'b0;
		end
		else
		begin
			tick_sync_ff <= {tick_sync_ff[1:0], dog_tick_clock_i};
			if (tick_agree)
				tick_prev_ff <= tick_sync_ff[2];
		end
	end

	// ****************************************
	// Boot strap capture
	// ****************************************
	// Strap caught one clock after release, never under reset
	reg                       strap_done_ff;
	reg                       en_ff;
	reg                       wake_en_ff;
	reg                       rst_en_ff;
	reg  [3:0]                sel_ff;
	reg  [1:0]                dly_sel_ff;

	// ****************************************
	// Counter and sequencer
	// ****************************************
	reg  [`DOG_CNT_W-1:0]     cnt_ff;
	reg  [1:0]                state_ff;
	reg  [10:0]               phase_cnt_ff;
	reg                       tof_ff;
	reg                       rstf_ff;
	reg                       wkf_ff;
	reg                       kick_ff;
	wire [4:0]                sel_eff = {1'b0, sel_ff} + 5'd4;
	// Selects above 14 saturate at the full 18-bit span
	wire [4:0]                sel_bit = (sel_eff > 5'd18) ? 5'd17 : sel_eff - 5'd1;
	wire [`DOG_CNT_W-1:0]     tmo_mask = (18'h00001 << (sel_bit + 5'd1)) - 18'h00001;
	wire                      timeout = (cnt_ff == tmo_mask); // [R03]
	reg  [10:0]               dly_len;

	always @*
	begin
		case (dly_sel_ff)
			2'd0:    dly_len = `DOG_DLY_0;
			2'd1:    dly_len = `DOG_DLY_1;
			2'd2:    dly_len = `DOG_DLY_2;
			default: dly_len = `DOG_DLY_3;
		endcase
	end

	wire                      tof_evt  = en_ff & tick_rise & timeout;
	wire                      wake_evt = tof_evt & wake_en_ff & src_is_10khz_i & low_power_i; // [R07]

	always @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			cnt_ff       <= {`DOG_CNT_W{1'b0}};
			state_ff     <= ST_RUN;
			phase_cnt_ff <= 11'h000;
		end
		else
		begin
			if (kick_ff | ~en_ff)
				cnt_ff <= {`DOG_CNT_W{1'b0}}; // [R08]
			else if (tick_rise)
				cnt_ff <= cnt_ff + 18'h00001; // [R02]
			case (state_ff)
				ST_RUN:
				begin
					if (tof_evt & rst_en_ff)
					begin
						state_ff     <= ST_DELAY; // [R01]
						phase_cnt_ff <= 11'h000;
					end
				end
				ST_DELAY:
				begin
					if (kick_ff | ~en_ff)
						state_ff <= ST_RUN;
					else if (tick_rise)
					begin
						if (phase_cnt_ff == dly_len - 11'h001)
						begin
							state_ff     <= ST_HOLD; // [R05]
							phase_cnt_ff <= 11'h000;
						end
						else
							phase_cnt_ff <= phase_cnt_ff + 11'h001;
					end
				end
				ST_HOLD:
				begin
					if (tick_rise)
					begin
						if (phase_cnt_ff[5:0] == `DOG_HOLD_TICKS - 6'h01)
						begin
							state_ff     <= ST_RUN; // [R04]
							phase_cnt_ff <= 11'h000;
						end
						else
							phase_cnt_ff <= phase_cnt_ff + 11'h001;
					end
				end
				default: state_ff <= ST_RUN;
			endcase
		end
	end

	assign sys_reset_o = (state_ff == ST_HOLD); // [R01]
	assign wake_o      = wkf_ff;

	// ****************************************
	// AXI4-Lite slave
	// ****************************************
	reg                       aw_got_ff;
	reg                       w_got_ff;
	reg  [3:0]                awaddr_ff;
	reg  [31:0]               wdata_ff;
	reg  [3:0]                wstrb_ff;
	reg                       bvalid_ff;
	reg  [1:0]                bresp_ff;
	reg                       rvalid_ff;
	reg  [1:0]                rresp_ff;
	reg  [31:0]               rdata_ff;
	wire                      wr_go = aw_got_ff & w_got_ff & ~bvalid_ff;
	wire                      w1c   = wr_go & (awaddr_ff == `DOG_STAT_OFS) & wstrb_ff[0];

	assign s_axi_awready_o = ~aw_got_ff & ~bvalid_ff;
	assign s_axi_wready_o  = ~w_got_ff & ~bvalid_ff;
	assign s_axi_bvalid_o  = bvalid_ff;
	assign s_axi_bresp_o   = bresp_ff;
	assign s_axi_arready_o = ~rvalid_ff;
	assign s_axi_rvalid_o  = rvalid_ff;
	assign s_axi_rresp_o   = rresp_ff;
	assign s_axi_rdata_o   = rdata_ff;

	always @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			aw_got_ff     <= 1'b0;
			w_got_ff      <= 1'b0;
			awaddr_ff     <= 4'h0;
			wdata_ff      <= 32'h00000000;
			wstrb_ff      <= 4'h0;
			bvalid_ff     <= 1'b0;
			bresp_ff      <= 2'b00;
			rvalid_ff     <= 1'b0;
			rresp_ff      <= 2'b00;
			rdata_ff      <= 32'h00000000;
			strap_done_ff <= 1'b0;
			en_ff         <= 1'b0;
			wake_en_ff    <= 1'b0;
			rst_en_ff     <= 1'b1;
			sel_ff        <= 4'h0;
			dly_sel_ff    <= 2'd3;
			kick_ff       <= 1'b0;
			tof_ff        <= 1'b0;
			rstf_ff       <= 1'b0;
			wkf_ff        <= 1'b0;
		end
		else
		begin
			kick_ff <= 1'b0;
			if (~strap_done_ff)
			begin
				strap_done_ff <= 1'b1;
				en_ff         <= ~boot_force_dog_on_bit_i; // [R06]
			end
			if (s_axi_awvalid_i & s_axi_awready_o)
			begin
				aw_got_ff <= 1'b1;
				awaddr_ff <= s_axi_awaddr_i[3:0];
			end
			if (s_axi_wvalid_i & s_axi_wready_o)
			begin
				w_got_ff <= 1'b1;
				wdata_ff <= s_axi_wdata_i;
				wstrb_ff <= s_axi_wstrb_i;
			end
			if (wr_go)
			begin
				aw_got_ff <= 1'b0;
				w_got_ff  <= 1'b0;
				bvalid_ff <= 1'b1;
				bresp_ff  <= 2'b00;
				case (awaddr_ff)
					`DOG_CTRL_OFS:
					begin
						if (wstrb_ff[0])
						begin
							en_ff      <= wdata_ff[`DOG_CTRL_EN_BIT];
							wake_en_ff <= wdata_ff[`DOG_CTRL_WAKE_BIT];
							rst_en_ff  <= wdata_ff[`DOG_CTRL_RSTEN_BIT];
							sel_ff     <= wdata_ff[`DOG_CTRL_SEL_MSB:`DOG_CTRL_SEL_LSB]; // [R03]
						end
						if (wstrb_ff[1])
							dly_sel_ff <= wdata_ff[`DOG_CTRL_DLY_MSB:`DOG_CTRL_DLY_LSB]; // [R05]
					end
					`DOG_STAT_OFS: ;
					`DOG_KICK_OFS:
						kick_ff <= (wdata_ff == `DOG_KICK_KEY); // [R08]
					default: bresp_ff <= 2'b10;
				endcase
			end
			else if (bvalid_ff & s_axi_bready_i)
				bvalid_ff <= 1'b0;
			// Set wins over a same-cycle write-one clear
			tof_ff  <= tof_evt  | (tof_ff  & ~(w1c & wdata_ff[`DOG_STAT_TOF_BIT]));
			// Kick or disable in the last delay tick aborts the reset, so no flag
			rstf_ff <= (state_ff == ST_DELAY & tick_rise & ~kick_ff & en_ff & phase_cnt_ff == dly_len - 11'h001)
			           | (rstf_ff & ~(w1c & wdata_ff[`DOG_STAT_RSTF_BIT]));
			wkf_ff  <= wake_evt | (wkf_ff  & ~(w1c & wdata_ff[`DOG_STAT_WKF_BIT]));
			if (s_axi_arvalid_i & s_axi_arready_o)
			begin
				rvalid_ff <= 1'b1;
				rresp_ff  <= 2'b00;
				case (s_axi_araddr_i[3:0])
					`DOG_CTRL_OFS: rdata_ff <= {22'h000000, dly_sel_ff, sel_ff, 1'b0, rst_en_ff, wake_en_ff, en_ff};
					`DOG_STAT_OFS: rdata_ff <= {6'h00, cnt_ff, 5'h00, wkf_ff, rstf_ff, tof_ff};
					`DOG_KICK_OFS: rdata_ff <= 32'h00000000;
					default:
					begin
						rdata_ff <= 32'h00000000;
						rresp_ff <= 2'b10;
					end
				endcase
			end
			else if (rvalid_ff & s_axi_rready_i)
				rvalid_ff <= 1'b0;
		end
	end

endmodule // watchdog_reset_timer

// *** watchdog_reset_timer_tb_top.sv ***
// Purpose: Self-checking bench for the watchdog reset timer
// Assumes: Tick clock much faster than 10 kHz to keep the run short
// Notes:   Time-out counts allow two ticks of filter slack
`timescale 1ns/1ps
`include "dog_defs.vh"
module watchdog_reset_timer_tb_top;
	reg         clk = 1'b0, rst = 1'b1, tck = 1'b0, boot = 1'b0, src = 1'b0, lp = 1'b0;
	reg  [31:0] awa = 32'h0, wd = 32'h0, ara = 32'h0;
	reg  [4:0]  vr = 5'h00;
	wire        awy, wy, ary, bv, rv, srst, wake;
	wire [1:0]  br, rr;
	wire [31:0] rdat;
	reg  [65:0] rq [$];
	reg  [1:0]  bq [$];
	reg  [65:0] e;
	reg  [10:0] dl [4] = '{`DOG_DLY_0, `DOG_DLY_1, `DOG_DLY_2, `DOG_DLY_3};
	integer     n_mismatch = 0, checked = 0, i, n, x;
	always #2 clk = ~clk;
	always #32.2 tck = ~tck;
	watchdog_reset_timer dut
	(
		.sys_clk_i(clk), .rst_i(rst), .dog_tick_clock_i(tck), .boot_force_dog_on_bit_i(boot),
		.src_is_10khz_i(src), .low_power_i(lp), .s_axi_awaddr_i(awa), .s_axi_awvalid_i(vr[4]),
		.s_axi_awready_o(awy), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(vr[3]),
		.s_axi_wready_o(wy), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(vr[2]),
		.s_axi_araddr_i(ara), .s_axi_arvalid_i(vr[1]), .s_axi_arready_o(ary), .s_axi_rdata_o(rdat),
		.s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(vr[0]), .sys_reset_o(srst), .wake_o(wake)
	);
	task cmp(input [31:0] g, input [31:0] v);
		begin
			checked = checked + 1;
			if (g !== v)
			begin
				n_mismatch = n_mismatch + 1;
				$display("ERROR t=%0t got=%h exp=%h", $time, g, v);
			end
		end
	endtask
	// ****
	// Response watcher, oldest note first
	// ****
	always @(posedge clk)
	begin
		if (rv && vr[0] && rq.size() > 0)
		begin
			e = rq.pop_front();
			cmp(rdat & e[63:32], e[31:0]);
			cmp({30'h0, rr}, {30'h0, e[65:64]});
		end
		if (bv && vr[2] && bq.size() > 0)
			cmp({30'h0, br}, {30'h0, bq.pop_front()});
	end
	task wr(input [31:0] a, input [31:0] d, input [1:0] r);
		begin
			bq.push_back(r);
			@(posedge clk);
			{awa, wd, vr[4:2]} <= {a, d, 3'h7};
			do
			begin
				@(posedge clk);
				if (awy) vr[4] <= 1'b0;
				if (wy) vr[3] <= 1'b0;
			end
			while ((vr[4] && !awy) || (vr[3] && !wy));
			do @(posedge clk); while (!bv);
			vr[2] <= 1'b0;
		end
	endtask
	task rd(input [31:0] a, input [31:0] m, input [31:0] v, input [1:0] r);
		begin
			rq.push_back({r, m, v});
			@(posedge clk);
			{ara, vr[1:0]} <= {a, 2'h3};
			do @(posedge clk); while (!ary);
			vr[1] <= 1'b0;
			do @(posedge clk); while (!rv);
			vr[0] <= 1'b0;
		end
	endtask
	// Counts raw ticks until the reset output reaches lv
	task tk(input lv);
		begin
			n = 0;
			while (srst !== lv)
			begin
				@(posedge tck);
				n = n + 1;
			end
		end
	endtask
	task tally_and_finish;
		begin
			$display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
			if (n_mismatch == 0 && checked > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	initial
	begin
		#200000;
		n_mismatch = n_mismatch + 1;
		tally_and_finish;
	end
	initial
	begin
		x = $urandom(32'h3f1a37b1);
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		rd(`DOG_CTRL_OFS, 32'h7, 32'h5, 2'h0);
		x = ($urandom & 32'hfffffff0) | 32'hc;
		rd(x, 32'hffffffff, 32'h0, 2'h2);
		wr(x, 32'h1, 2'h2);
		wr(`DOG_CTRL_OFS, 32'h5, 2'h0);
		// Kicks spaced half a time-out apart
		repeat (6)
		begin
			wr(`DOG_KICK_OFS, `DOG_KICK_KEY, 2'h0);
			repeat (8) @(posedge tck);
		end
		cmp({31'h0, srst}, 32'h0);
		lp <= 1'b1;
		for (i = 0; i < 4; i = i + 1)
		begin
			src <= i[0];
			x = 32'h7 | (i[0] << 4) | (i << 8);
			wr(`DOG_CTRL_OFS, x, 2'h0);
			rd(`DOG_CTRL_OFS, 32'h3ff, x, 2'h0);
			wr(`DOG_KICK_OFS, `DOG_KICK_KEY, 2'h0);
			x = (16 << i[0]) + dl[i];
			tk(1'b1);
			cmp({31'h0, n >= x - 2 && n <= x + 2}, 32'h1);
			cmp({31'h0, wake}, {31'h0, i[0]});
			tk(1'b0);
			cmp(n, 32'h3f);
			rd(`DOG_STAT_OFS, 32'h7, 32'h3 | (i[0] << 2), 2'h0);
			wr(`DOG_STAT_OFS, 32'h7, 2'h0);
			rd(`DOG_STAT_OFS, 32'h7, 32'h0, 2'h0);
		end
		{rst, boot} <= 2'h3;
		repeat (2) @(posedge clk);
		cmp({30'h0, srst, wake}, 32'h0);
		rst <= 1'b0;
		rd(`DOG_CTRL_OFS, 32'h7, 32'h4, 2'h0);
		tally_and_finish;
	end
endmodule // watchdog_reset_timer_tb_top

// *** wdt_props_properties.sv ***
// Purpose: Port checks for the watchdog reset timer
// Assumes: Tick clock far slower than sys_clk_i
// Notes:   Hold length counted in raw tick edges
`timescale 1ns/1ps
module wdt_props
(
	input wire sys_clk_i,
	input wire rst_i,
	input wire dog_tick_clock_i,
	input wire src_is_10khz_i,
	input wire s_axi_awvalid_i,
	input wire s_axi_awready_o,
	input wire s_axi_wvalid_i,
	input wire s_axi_wready_o,
	input wire s_axi_bvalid_o,
	input wire s_axi_arvalid_i,
	input wire s_axi_arready_o,
	input wire s_axi_rvalid_o,
	input wire sys_reset_o,
	input wire wake_o
);
	// ****
	// Raw tick edges while reset is held
	// ****
	reg       tq_ff;
	reg [7:0] n_ff;
	always @(posedge sys_clk_i or posedge rst_i)
		if (rst_i)
			{tq_ff, n_ff} <= 9'h000;
		else
			{tq_ff, n_ff} <= {dog_tick_clock_i, sys_reset_o ? n_ff + {7'h00, dog_tick_clock_i & ~tq_ff} : 8'h00};
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	a_hold_len: assert property ($fell(sys_reset_o) |-> n_ff == 8'h3f) else $error("hold length");
	a_hold_cap: assert property (sys_reset_o |-> n_ff <= 8'h3f) else $error("hold too long");
	a_hold_min: assert property ($rose(sys_reset_o) |=> sys_reset_o [*8]) else $error("reset glitch");
	a_wake_source: assert property ($rose(wake_o) |-> src_is_10khz_i) else $error("wake source");
	// Both channels are latched first, the response follows one cycle later
	a_write_answer: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
		|-> ##2 s_axi_bvalid_o) else $error("write answer");
	a_write_busy: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o) else $error("write busy");
	a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o) else $error("read answer");
	a_read_busy: assert property (s_axi_rvalid_o |-> !s_axi_arready_o) else $error("read busy");
endmodule // wdt_props
bind watchdog_reset_timer wdt_props u_props (.*);
